// >>> inc/tmr_consts.vh
// Register offsets, field positions, reset values and timing counts of the timer.
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
`define TMR_OFS_CONTROL   12'h000
`define TMR_OFS_COUNTER   12'h004
`define TMR_OFS_COMPARE   12'h008
`define TMR_OFS_ASYNC     12'h00c
`define TMR_OFS_FLAGS     12'h010
`define TMR_CTL_FORCE     7
`define TMR_CTL_WGM0      6
`define TMR_CTL_COM_HI    5
`define TMR_CTL_COM_LO    4
`define TMR_CTL_WGM1      3
`define TMR_CTL_CS_HI     2
`define TMR_CTL_CS_LO     0
`define TMR_ST_ASEL       3
`define TMR_ST_CNT_BUSY   2
`define TMR_ST_CMP_BUSY   1
`define TMR_ST_CTL_BUSY   0
`define TMR_FL_MATCH      1
`define TMR_FL_VECTOR_ACK 0
`define TMR_RST_BYTE      8'h00
`define TMR_TOP_MAX       8'hff
`define TMR_MODE_NORMAL   2'h0
`define TMR_MODE_PCPWM    2'h1
`define TMR_MODE_CLEAR    2'h2
`define TMR_MODE_FAST     2'h3
`define TMR_ASYNC_EDGES   2'h2
`endif

// >>> rtl/tmr_timer8.v
// Eight-bit timer with compare output, prescaler and asynchronous-clock holding registers.
//
// Overview of operation
// - Nonzero output mode routes compare onto pin.
// - Non-PWM: off, toggle, clear, set on match.
// - Fast PWM: clear/set on match, opposite at top.
// - Phase PWM: action by direction, reversed downward.
// - Match at top in PWM acts at top.
// - Clock select stops or divides source clock.
// - Counter writable; write blocks next match.
// - Compare register continuously compared with counter.
// - Select bit picks I/O clock or oscillator.
// - Counter write sets counter busy flag.
// - Compare write sets compare busy flag.
// - Control write sets control busy flag.
// - Counter reads live; control and compare read holding.
// - Held values land after two oscillator edges.
// - Mode field picks normal, phase, clear-on-match, fast.
// - Match sets flag; vector or one clears.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "tmr_consts.vh"
module tmr_timer8 (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        oscillator_input_pin,
  input  wire        match_vector_ack,
  output reg         compare_output_pin,
  output reg         compare_output_enable,
  output reg         compare_match_flag
);

  // Prescaler ratio for a clock select code.
  function [10:0] tmr_ratio;
    input [2:0] cs;
    begin
      case (cs)
        3'h2:    tmr_ratio = 11'h008;
        3'h3:    tmr_ratio = 11'h020;
        3'h4:    tmr_ratio = 11'h040;
        3'h5:    tmr_ratio = 11'h080;
        3'h6:    tmr_ratio = 11'h100;
        3'h7:    tmr_ratio = 11'h400;
        default: tmr_ratio = 11'h001;
      endcase
    end
  endfunction

  // True for the two PWM waveform modes.
  function tmr_is_pwm;
    input [1:0] wgm;
    begin
      tmr_is_pwm = (wgm == `TMR_MODE_PCPWM) || (wgm == `TMR_MODE_FAST);
    end
  endfunction

  // Output level after a non-PWM match for an output mode code.
  function tmr_action;
    input [1:0] mode;
    input       level;
    begin
      case (mode)
        2'h1:    tmr_action = ~level;
        2'h2:    tmr_action = 1'b0;
        2'h3:    tmr_action = 1'b1;
        default: tmr_action = level;
      endcase
    end
  endfunction

  // Two-stage synchroniser on the oscillator pin.
  reg osc_meta;
  reg osc_sync;
  reg osc_prev;
  always @(posedge sys_clk) begin
    osc_meta <= oscillator_input_pin;
    osc_sync <= osc_meta;
    osc_prev <= osc_sync;
  end
  wire osc_rise = osc_sync & ~osc_prev;

  // Registered state.
  reg  [7:0] timer_control;
  reg  [7:0] counter_value;
  reg  [7:0] compare_value;
  reg  [7:0] hold_control;
  reg  [7:0] hold_counter;
  reg  [7:0] hold_compare;
  reg        async_clock_select;
  reg        counter_update_busy;
  reg        compare_update_busy;
  reg        control_update_busy;
  reg  [1:0] cnt_edges;
  reg  [1:0] cmp_edges;
  reg  [1:0] ctl_edges;
  reg [10:0] prescale;
  reg        count_down;
  reg        block_match;
  reg        wave;
  reg  [7:0] compare_active;

  // Field decode of the live control register.
  wire [1:0] waveform_mode_select = {timer_control[`TMR_CTL_WGM1], timer_control[`TMR_CTL_WGM0]};
  wire [1:0] compare_output_mode  = timer_control[`TMR_CTL_COM_HI:`TMR_CTL_COM_LO];
  wire [2:0] count_clock_select   = timer_control[`TMR_CTL_CS_HI:`TMR_CTL_CS_LO];
  wire       is_pwm = tmr_is_pwm(waveform_mode_select);
  wire [7:0] top = (waveform_mode_select == `TMR_MODE_CLEAR) ? compare_value : `TMR_TOP_MAX;

  // source select: one source tick per sys_clk or per oscillator edge.
  wire src_tick = async_clock_select ? osc_rise : 1'b1;
  // clock select divides the source clock.
  wire [10:0] ratio = tmr_ratio(count_clock_select);
  wire tmr_tick = src_tick && (count_clock_select != 3'h0) && (prescale >= ratio - 11'h001);

  // APB decode.
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_ctl  = paddr == `TMR_OFS_CONTROL;
  wire hit_cnt  = paddr == `TMR_OFS_COUNTER;
  wire hit_cmp  = paddr == `TMR_OFS_COMPARE;
  wire hit_asy  = paddr == `TMR_OFS_ASYNC;
  wire hit_flg  = paddr == `TMR_OFS_FLAGS;
  wire mapped   = hit_ctl | hit_cnt | hit_cmp | hit_asy | hit_flg;
  wire wr_ctl   = wr && hit_ctl;
  wire wr_cnt   = wr && hit_cnt;
  wire wr_cmp   = wr && hit_cmp;

  // holding registers land after two oscillator edges in async mode.
  wire land_cnt = counter_update_busy && osc_rise && (cnt_edges == `TMR_ASYNC_EDGES - 2'h1);
  wire land_cmp = compare_update_busy && osc_rise && (cmp_edges == `TMR_ASYNC_EDGES - 2'h1);
  wire land_ctl = control_update_busy && osc_rise && (ctl_edges == `TMR_ASYNC_EDGES - 2'h1);

  // continuous equality of counter and compare.
  wire raw_match = (counter_value == compare_value);
  // a PWM match at top is ignored; the action moves to top.
  wire at_top_special = is_pwm && compare_output_mode[1] && (compare_value == top);
  wire match_ev = tmr_tick && raw_match && !block_match;
  // The force strobe acts with the mode bits of its own write, so software can pick
  // the action and force it at once; in the PWM modes the strobe does nothing.
  wire [1:0] force_wgm  = {pwdata[`TMR_CTL_WGM1], pwdata[`TMR_CTL_WGM0]};
  wire [1:0] force_mode = pwdata[`TMR_CTL_COM_HI:`TMR_CTL_COM_LO];
  wire       force_pwm  = tmr_is_pwm(force_wgm);
  wire       force_ev   = wr_ctl && pwdata[`TMR_CTL_FORCE] && !force_pwm;

  // Prescaler counter.
  always @(posedge sys_clk) begin
    if (rst || count_clock_select == 3'h0) begin
      prescale <= 11'h000;
    end else if (src_tick) begin
      prescale <= (prescale >= ratio - 11'h001) ? 11'h000 : prescale + 11'h001;
    end
  end

  // Busy flags, edge counters and holding-register transfers.
  always @(posedge sys_clk) begin
    if (rst) begin
      hold_control        <= `TMR_RST_BYTE;
      hold_counter        <= `TMR_RST_BYTE;
      hold_compare        <= `TMR_RST_BYTE;
      counter_update_busy <= 1'b0;
      compare_update_busy <= 1'b0;
      control_update_busy <= 1'b0;
      cnt_edges           <= 2'h0;
      cmp_edges           <= 2'h0;
      ctl_edges           <= 2'h0;
      async_clock_select  <= 1'b0;
    end else begin
      if (wr && hit_asy) begin
        async_clock_select <= pwdata[`TMR_ST_ASEL];
      end
      if (wr_cnt) begin
        hold_counter        <= pwdata[7:0];
        counter_update_busy <= async_clock_select;
        cnt_edges           <= 2'h0;
      end else if (land_cnt) begin
        counter_update_busy <= 1'b0;
      end else if (counter_update_busy && osc_rise) begin
        cnt_edges <= cnt_edges + 2'h1;
      end
      if (wr_cmp) begin
        hold_compare        <= pwdata[7:0];
        compare_update_busy <= async_clock_select;
        cmp_edges           <= 2'h0;
      end else if (land_cmp) begin
        compare_update_busy <= 1'b0;
      end else if (compare_update_busy && osc_rise) begin
        cmp_edges <= cmp_edges + 2'h1;
      end
      // control write raises control busy; force bit is never held.
      if (wr_ctl) begin
        hold_control        <= {1'b0, pwdata[6:0]};
        control_update_busy <= async_clock_select;
        ctl_edges           <= 2'h0;
      end else if (land_ctl) begin
        control_update_busy <= 1'b0;
      end else if (control_update_busy && osc_rise) begin
        ctl_edges <= ctl_edges + 2'h1;
      end
    end
  end

  // Destination registers, counter engine and match blocking.
  always @(posedge sys_clk) begin
    if (rst) begin
      timer_control <= `TMR_RST_BYTE;
      compare_value <= `TMR_RST_BYTE;
      counter_value <= `TMR_RST_BYTE;
      count_down    <= 1'b0;
      block_match   <= 1'b0;
    end else begin
      if ((wr_ctl && !async_clock_select) || land_ctl) begin
        timer_control <= wr_ctl ? {1'b0, pwdata[6:0]} : hold_control;
      end
      if ((wr_cmp && !async_clock_select) || land_cmp) begin
        compare_value <= wr_cmp ? pwdata[7:0] : hold_compare;
      end
      // a counter write blocks the match on the next timer tick.
      if ((wr_cnt && !async_clock_select) || land_cnt) begin
        counter_value <= wr_cnt ? pwdata[7:0] : hold_counter;
        block_match   <= 1'b1;
      end else if (tmr_tick) begin
        block_match <= 1'b0;
        if (waveform_mode_select == `TMR_MODE_PCPWM) begin
          if (!count_down && counter_value == `TMR_TOP_MAX) begin
            count_down    <= 1'b1;
            counter_value <= counter_value - 8'h01;
          end else if (count_down && counter_value == 8'h00) begin
            count_down    <= 1'b0;
            counter_value <= 8'h01;
          end else begin
            counter_value <= count_down ? counter_value - 8'h01 : counter_value + 8'h01;
          end
        end else begin
          count_down    <= 1'b0;
          counter_value <= (counter_value == top) ? 8'h00 : counter_value + 8'h01;
        end
      end
    end
  end

  // Waveform generator and pin drive.
  always @(posedge sys_clk) begin
    if (rst) begin
      wave                  <= 1'b0;
      compare_output_pin    <= 1'b0;
      compare_output_enable <= 1'b0;
      compare_active        <= `TMR_RST_BYTE;
    end else begin
      compare_active <= compare_value;
      // non-PWM actions; a forced match uses the mode bits written with it.
      if (force_ev) begin
        wave <= tmr_action(force_mode, wave);
      end else if (!is_pwm && match_ev) begin
        wave <= tmr_action(compare_output_mode, wave);
      // fast PWM: match and top give opposite levels.
      end else if (waveform_mode_select == `TMR_MODE_FAST && compare_output_mode[1] && tmr_tick) begin
        // the top action wins, so a match at top is ignored.
        if (counter_value == top) begin
          wave <= ~compare_output_mode[0];
        end else if (raw_match && !block_match) begin
          wave <= compare_output_mode[0];
        end
      // phase PWM: action depends on count direction.
      end else if (waveform_mode_select == `TMR_MODE_PCPWM && compare_output_mode[1] && tmr_tick) begin
        if (at_top_special && counter_value == top) begin
          wave <= ~compare_output_mode[0];
        end else if (raw_match && !block_match && !at_top_special) begin
          wave <= count_down ? ~compare_output_mode[0] : compare_output_mode[0];
        end
      end
      // any nonzero mode takes the pin over.
      compare_output_enable <= compare_output_mode != 2'h0;
      compare_output_pin    <= wave;
    end
  end

  // match flag: set wins over vector or write-one clear.
  always @(posedge sys_clk) begin
    if (rst) begin
      compare_match_flag <= 1'b0;
    end else if (match_ev) begin
      compare_match_flag <= 1'b1;
    end else if (match_vector_ack || (wr && hit_flg && pwdata[`TMR_FL_MATCH])) begin
      compare_match_flag <= 1'b0;
    end
  end

  // APB slave: no wait state; reads of counter live, control and compare holding.
  always @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        // counter reads live; control and compare read holding.
        if (hit_cnt) prdata[7:0] <= counter_value;
        if (hit_cmp) prdata[7:0] <= hold_compare;
        if (hit_ctl) prdata[7:0] <= hold_control;
        if (hit_asy) prdata[3:0] <= {async_clock_select, counter_update_busy,
                                     compare_update_busy, control_update_busy};
        if (hit_flg) prdata[`TMR_FL_MATCH] <= compare_match_flag;
      end
    end
  end

endmodule

// >>> test/timer8_compare_async_ctrl_tb_top.sv
// Self-checking bench of the timer registers, compare output and asynchronous updates.
`timescale 1ns/1ns
`include "tmr_consts.vh"
module timer8_compare_async_ctrl_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        ack = 1'b0;
  logic        osc_run = 1'b0;
  wire         osc;
  wire  [31:0] prdata;
  wire         pready, pslverr, pin, pin_en, flag;
  logic [31:0] rv;
  logic        re;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  // Clock of 40 ns period.
  always #20 sys_clk = ~sys_clk;
  tmr_timer8 dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscillator_input_pin(osc),
    .match_vector_ack(ack), .compare_output_pin(pin), .compare_output_enable(pin_en), .compare_match_flag(flag));
  tmr_xtal_model xtal (.run(osc_run), .osc(osc));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task t_regs;
    rdc(`TMR_OFS_CONTROL, 32'h0);
    rdc(`TMR_OFS_ASYNC, 32'h0);
    apb(1'b1, `TMR_OFS_COMPARE, 32'h5a);
    rdc(`TMR_OFS_COMPARE, 32'h5a);
    apb(1'b1, `TMR_OFS_CONTROL, 32'hb8);
    rdc(`TMR_OFS_CONTROL, 32'h38);
    apb(1'b0, 12'h020, 32'h0);
    chk({re, rv[30:0]}, 32'h80000000);
  endtask
  task t_out;
    logic [7:0] code [4] = '{8'h90, 8'h90, 8'hb0, 8'ha0};
    logic       pv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    // the pin level is judged only together with its driver enable.
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `TMR_OFS_CONTROL, {24'h0, code[i]});
      repeat (2) @(posedge sys_clk);
      chk({pin_en, pin}, {1'b1, pv[i]});
    end
    apb(1'b1, `TMR_OFS_CONTROL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(pin_en, 1'b0);
  endtask
  task t_count;
    logic [31:0] c1;
    apb(1'b1, `TMR_OFS_COMPARE, 32'h5);
    apb(1'b1, `TMR_OFS_COUNTER, 32'h0);
    apb(1'b1, `TMR_OFS_CONTROL, 32'h31);
    repeat (20) @(posedge sys_clk);
    apb(1'b1, `TMR_OFS_CONTROL, 32'h30);
    chk({flag, pin}, 2'h3);
    apb(1'b0, `TMR_OFS_COUNTER, 32'h0);
    c1 = rv;
    chk(c1 > 32'd20 && c1 < 32'd32, 1'b1);
    rdc(`TMR_OFS_COUNTER, c1);
    apb(1'b1, `TMR_OFS_FLAGS, 32'h2);
    chk(flag, 1'b0);
    apb(1'b1, `TMR_OFS_COUNTER, 32'h0);
    apb(1'b1, `TMR_OFS_CONTROL, 32'h02);
    repeat (80) @(posedge sys_clk);
    apb(1'b1, `TMR_OFS_CONTROL, 32'h0);
    apb(1'b0, `TMR_OFS_COUNTER, 32'h0);
    chk(rv >= 32'd9 && rv <= 32'd12 && flag === 1'b1, 1'b1);
    ack <= 1'b1;
    @(posedge sys_clk);
    ack <= 1'b0;
    @(posedge sys_clk);
    chk(flag, 1'b0);
  endtask
  task t_async;
    logic [11:0] ad [3] = '{`TMR_OFS_CONTROL, `TMR_OFS_COMPARE, `TMR_OFS_COUNTER};
    logic [7:0]  vl [3] = '{8'h00, 8'h33, 8'h40};
    logic [7:0]  bz [3] = '{8'h01, 8'h02, 8'h04};
    int          n;
    osc_run <= 1'b1;
    apb(1'b1, `TMR_OFS_ASYNC, 32'h08);
    rdc(`TMR_OFS_ASYNC, 32'h08);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ad[i], {24'h0, vl[i]});
      rdc(`TMR_OFS_ASYNC, {24'h0, 8'h08 | bz[i]});
      n = 0;
      while (rv[2:0] !== 3'h0 && n < 100) begin
        n++;
        apb(1'b0, `TMR_OFS_ASYNC, 32'h0);
      end
      chk(rv, 32'h08);
      rdc(ad[i], {24'h0, vl[i]});
    end
    apb(1'b1, `TMR_OFS_ASYNC, 32'h0);
    apb(1'b1, `TMR_OFS_CONTROL, 32'h0);
    apb(1'b1, `TMR_OFS_COUNTER, 32'h0);
    osc_run <= 1'b0;
  endtask
  // Loads compare and counter, runs k+3 timer ticks at full rate, then stops the clock.
  task run_ticks(input logic [7:0] c, input logic [7:0] v, input logic [7:0] ctl, input int k);
    apb(1'b1, `TMR_OFS_COMPARE, {24'h0, c});
    apb(1'b1, `TMR_OFS_COUNTER, {24'h0, v});
    apb(1'b1, `TMR_OFS_CONTROL, {24'h0, ctl});
    repeat (k) @(posedge sys_clk);
    apb(1'b1, `TMR_OFS_CONTROL, {24'h0, ctl & 8'hf8});
    @(posedge sys_clk);
  endtask
  // Fast PWM, phase-correct PWM and clear-on-match counting.
  task t_pwm;
    run_ticks(8'h10, 8'h0c, 8'h69, 3);
    chk({pin_en, pin}, 2'h2);
    run_ticks(8'h10, 8'hfd, 8'h69, 1);
    chk({pin_en, pin}, 2'h3);
    run_ticks(8'hff, 8'hfd, 8'h79, 1);
    chk({pin_en, pin}, 2'h2);
    run_ticks(8'hf0, 8'hfd, 8'h61, 15);
    chk({pin_en, pin}, 2'h3);
    run_ticks(8'h05, 8'h00, 8'h61, 4);
    chk({pin_en, pin}, 2'h2);
    run_ticks(8'h03, 8'h00, 8'h19, 5);
    rdc(`TMR_OFS_COUNTER, 32'h0);
    apb(1'b1, `TMR_OFS_CONTROL, 32'h0);
  endtask
  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_out();
    t_count();
    t_async();
    t_pwm();
    give_verdict();
  end
endmodule

// >>> test/tmr_timer8_checker.sv
// Checker of bus answers, holding-register reads and compare output routing.
`timescale 1ns/1ns
`include "tmr_consts.vh"
module tmr_timer8_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        compare_output_enable
);
  logic [7:0] ctl_s;
  logic [7:0] cmp_s;
  logic       asel_s;
  wire        wr_acc = psel && penable && pwrite && pready;
  wire        rd_acc = psel && penable && !pwrite && pready;
  // Shadows of the last written values, as the holding registers should show them.
  always @(posedge sys_clk) begin
    if (rst) begin
      ctl_s <= 8'h00;
      cmp_s <= 8'h00;
      asel_s <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == `TMR_OFS_CONTROL) ctl_s <= pwdata[7:0];
      if (paddr == `TMR_OFS_COMPARE) cmp_s <= pwdata[7:0];
      if (paddr == `TMR_OFS_ASYNC) asel_s <= pwdata[3];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ready_answer_a: assert property (psel && !penable |=> pready)
    else $error("No answer in the access cycle.");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready held longer than one cycle.");
  slverr_map_a: assert property (pready |-> pslverr == !(paddr == `TMR_OFS_CONTROL || paddr == `TMR_OFS_COUNTER ||
    paddr == `TMR_OFS_COMPARE || paddr == `TMR_OFS_ASYNC || paddr == `TMR_OFS_FLAGS))
    else $error("Error response does not match the address map.");
  upper_zero_a: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("Upper read data bits not zero.");
  cmp_hold_a: assert property (rd_acc && paddr == `TMR_OFS_COMPARE |-> prdata[7:0] == cmp_s)
    else $error("Compare read differs from last written value.");
  ctl_hold_a: assert property (rd_acc && paddr == `TMR_OFS_CONTROL |-> prdata[7:0] == {1'b0, ctl_s[6:0]})
    else $error("Control read differs from last written value.");
  asel_read_a: assert property (rd_acc && paddr == `TMR_OFS_ASYNC |-> prdata[7:3] == {4'h0, asel_s})
    else $error("Clock select read wrong.");
  enable_route_a: assert property (wr_acc && paddr == `TMR_OFS_CONTROL && !asel_s
    |-> ##[1:2] compare_output_enable == (ctl_s[5:4] != 2'h0))
    else $error("Pin routing does not follow output mode.");
  cover property (wr_acc && paddr == `TMR_OFS_CONTROL);
  cover property (pready && pslverr);
  cover property ($rose(compare_output_enable));
endmodule
bind tmr_timer8 tmr_timer8_checker chk_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_output_enable(compare_output_enable));

// >>> test/tmr_xtal_model.sv
// Watch crystal model that toggles the oscillator pin only while enabled.
`timescale 1ns/1ns
module tmr_xtal_model #(parameter int HALF_NS = 200) (
  input  wire logic run,
  output      logic osc
);
  // Toggles while running; rests low between runs, so no edge reaches the timer.
  initial begin
    osc = 1'b0;
    #13;
    forever begin
      #HALF_NS;
      osc = run ? ~osc : 1'b0;
    end
  end
endmodule
